// ===== design/dda_pkg.sv
// Package: offsets, reset values and modes of the distributed DMA address/count block
package dda_pkg;
  // ****************************************
  // Window decode
  // ****************************************
  localparam logic [7:0] DDA_CFG_BASE_OFFSET = 8'h98;
  localparam int DDA_WINDOW_BYTES = 16;
  localparam int DDA_WINDOW_BITS = 4;
  // ****************************************
  // Register offsets within the window
  // ****************************************
  localparam logic [3:0] DDA_OFS_ADDR = 4'h0;
  localparam logic [3:0] DDA_OFS_PAGE = 4'h2;
  localparam logic [3:0] DDA_OFS_COUNT = 4'h4;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] DDA_ADDR_RST = 16'h0000;
  localparam logic [7:0] DDA_PAGE_RST = 8'h00;
  localparam logic [15:0] DDA_COUNT_RST = 16'h0000;
  localparam logic [31:0] DDA_IOBASE_RST = 32'h0000_0000;
  // ****************************************
  // Count steps and transfer width
  // ****************************************
  localparam logic [15:0] DDA_STEP_8 = 16'h0001;
  localparam logic [15:0] DDA_STEP_16 = 16'h0002;
  typedef enum logic {DDA_W8, DDA_W16} dda_width_e;
endpackage

// ===== design/dda_rd_if.sv
// Interface: register read path between the decoder and the core
`timescale 1ns/1ps
`default_nettype none
interface dda_rd_if;
  logic [3:0] ofs;
  logic [15:0] data;
  modport core (input ofs, output data);
  modport dec (output ofs, input data);
endinterface
`default_nettype wire

// ===== design/dda_rd_mux.sv
// Read multiplexer for the distributed DMA address/count window
`timescale 1ns/1ps
`default_nettype none
module dda_rd_mux
  import dda_pkg::*;
(
  dda_rd_if.core rd,
  input wire logic [15:0] cur_addr,
  input wire logic [7:0] page,
  input wire logic [15:0] cur_count
);
  // ****************************************
  // Read data select
  // ****************************************
  // Unlisted offsets read zero
  always_comb begin
    unique case (rd.ofs)
      DDA_OFS_ADDR: rd.data = cur_addr;
      DDA_OFS_PAGE: rd.data = {8'h00, page};
      DDA_OFS_COUNT: rd.data = cur_count;
      default: rd.data = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// ===== design/dda_core.sv
// Distributed DMA address/count section: window decode, registers, bus address
// Function
// - Decode 16-byte I/O window from base
// - Obsolete legacy bits are read-only, inert
// - Reserved locations read zero, ignore writes
// - Offset 00h writes base, reads current
// - Offset 02h holds 8-bit page
// - 8-bit mode: address on AD15-AD0
// - 8-bit mode: page on AD23-AD16
// - 16-bit mode: address shifted onto AD16-AD1
// - 16-bit mode: AD0 driven low
// - 16-bit mode: page[7:1] on AD23-AD17
// - Offset 04h writes base, reads current count
// - 8-bit mode: count minus one per transfer
// - 16-bit mode: count minus two per transfer
`timescale 1ns/1ps
`default_nettype none
module dda_core
  import dda_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] io_base,
  input wire logic [31:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  input wire logic [1:0] io_be,
  output logic io_hit,
  output logic [15:0] io_rdata,
  input wire logic xfer_16,
  input wire logic xfer_done,
  input wire logic addr_dec,
  output logic [31:0] ad_addr,
  output logic terminal_count
);
  // ****************************************
  // Window decode
  // ****************************************
  logic [3:0] ofs;
  logic wr_addr;
  logic wr_page;
  logic wr_count;
  logic rsvd_hit;
  dda_width_e width;
  dda_rd_if rd ();
  // Hit on the 16-byte window above the base
  always_comb begin
    io_hit = (io_addr[31:DDA_WINDOW_BITS] == io_base[31:DDA_WINDOW_BITS]);
    ofs = io_addr[DDA_WINDOW_BITS-1:0];
    wr_addr = io_hit && io_wr && (ofs == DDA_OFS_ADDR);
    wr_page = io_hit && io_wr && (ofs == DDA_OFS_PAGE) && io_be[0];
    wr_count = io_hit && io_wr && (ofs == DDA_OFS_COUNT);
    rsvd_hit = io_hit && (ofs != DDA_OFS_ADDR) && (ofs != DDA_OFS_PAGE)
      && (ofs != DDA_OFS_COUNT);
    width = xfer_16 ? DDA_W16 : DDA_W8;
  end
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] base_addr_reg, base_addr_next;
  logic [15:0] cur_addr_reg, cur_addr_next;
  logic [7:0] page_reg, page_next;
  logic [15:0] base_count_reg, base_count_next;
  logic [15:0] cur_count_reg, cur_count_next;
  logic [15:0] step;
  logic [15:0] wmask;
  // Next values: writes load base and current, transfers advance current
  always_comb begin
    wmask = {{8{io_be[1]}}, {8{io_be[0]}}};
    step = (width == DDA_W16) ? DDA_STEP_16 : DDA_STEP_8;
    base_addr_next = base_addr_reg;
    cur_addr_next = cur_addr_reg;
    page_next = page_reg;
    base_count_next = base_count_reg;
    cur_count_next = cur_count_reg;
    if (xfer_done) begin
      cur_count_next = cur_count_reg - step;
      cur_addr_next = addr_dec ? cur_addr_reg - 16'h0001 : cur_addr_reg + 16'h0001;
    end
    if (wr_addr) begin
      base_addr_next = (base_addr_reg & ~wmask) | (io_wdata & wmask);
      cur_addr_next = base_addr_next;
    end
    if (wr_page) begin
      page_next = io_wdata[7:0];
    end
    if (wr_count) begin
      base_count_next = (base_count_reg & ~wmask) | (io_wdata & wmask);
      cur_count_next = base_count_next;
    end
  end
  // Register update with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_addr_reg <= DDA_ADDR_RST;
      cur_addr_reg <= DDA_ADDR_RST;
      page_reg <= DDA_PAGE_RST;
      base_count_reg <= DDA_COUNT_RST;
      cur_count_reg <= DDA_COUNT_RST;
    end else begin
      base_addr_reg <= base_addr_next;
      cur_addr_reg <= cur_addr_next;
      page_reg <= page_next;
      base_count_reg <= base_count_next;
      cur_count_reg <= cur_count_next;
    end
  end
  // ****************************************
  // Read path
  // ****************************************
  logic [15:0] rdata_next;
  logic [15:0] rdata_reg;
  assign rd.ofs = ofs;
  dda_rd_mux u_rd_mux (
    .rd(rd),
    .cur_addr(cur_addr_reg),
    .page(page_reg),
    .cur_count(cur_count_reg)
  );
  // Read data registered; misses read zero
  always_comb begin
    rdata_next = (io_hit && io_rd) ? rd.data : 16'h0000;
  end
  // Read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign io_rdata = rdata_reg;
  // ****************************************
  // Address phase value
  // ****************************************
  logic [31:0] ad_next;
  logic [31:0] ad_reg;
  logic tc_reg;
  logic tc_next;
  // Byte mode keeps the address, word mode shifts it up one; both follow the
  // next-state registers so a write or a transfer shows in the very next cycle
  always_comb begin
    // Terminal count marks a transfer that takes the count below zero
    tc_next = xfer_done && (cur_count_reg < step);
    if (width == DDA_W16) begin
      ad_next = {8'h00, page_next[7:1], cur_addr_next, 1'b0};
    end else begin
      ad_next = {8'h00, page_next, cur_addr_next};
    end
  end
  // Address phase and terminal count registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ad_reg <= 32'h0000_0000;
      tc_reg <= 1'b0;
    end else begin
      ad_reg <= ad_next;
      tc_reg <= tc_next;
    end
  end
  assign ad_addr = ad_reg;
  assign terminal_count = tc_reg;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Address phase in byte mode
  byte_addr_a: assert property (!xfer_16 |=> ad_addr[15:0] == cur_addr_reg)
    else $error("byte address phase wrong");
  byte_page_a: assert property (!xfer_16 |=> ad_addr[23:16] == page_reg)
    else $error("byte page wrong");
  // Address phase in word mode
  word_shift_a: assert property (xfer_16 |=> ad_addr[16:1] == cur_addr_reg)
    else $error("word address shift wrong");
  word_ad0_a: assert property (xfer_16 |=> ad_addr[0] == 1'b0)
    else $error("AD0 not low in word mode");
  word_page_a: assert property (xfer_16 |=> ad_addr[23:17] == page_reg[7:1])
    else $error("word page wrong");
  // Top address byte stays zero
  ad_top_a: assert property (ad_addr[31:24] == 8'h00)
    else $error("address top byte not zero");
  // Count steps per completed transfer
  count_byte_a: assert property (xfer_done && !xfer_16 && !wr_count |=>
    cur_count_reg == $past(cur_count_reg) - 16'h0001)
    else $error("byte count step wrong");
  count_word_a: assert property (xfer_done && xfer_16 && !wr_count |=>
    cur_count_reg == $past(cur_count_reg) - 16'h0002)
    else $error("word count step wrong");
  // Base writes with both bytes load base and current
  base_load_a: assert property (wr_count && io_be == 2'b11 |=>
    cur_count_reg == $past(io_wdata) && base_count_reg == $past(io_wdata))
    else $error("count load wrong");
  addr_load_a: assert property (wr_addr && io_be == 2'b11 |=>
    cur_addr_reg == $past(io_wdata) && base_addr_reg == $past(io_wdata))
    else $error("address load wrong");
  // Page takes only its low byte lane
  page_load_a: assert property (wr_page |=> page_reg == $past(io_wdata[7:0]))
    else $error("page load wrong");
  page_keep_a: assert property (io_hit && io_wr && ofs == DDA_OFS_PAGE && !io_be[0] |=>
    $stable(page_reg))
    else $error("page changed without low byte enable");
  // Reads return the live registers
  addr_read_a: assert property (io_hit && io_rd && ofs == DDA_OFS_ADDR |=>
    io_rdata == $past(cur_addr_reg))
    else $error("address read wrong");
  count_read_a: assert property (io_hit && io_rd && ofs == DDA_OFS_COUNT |=>
    io_rdata == $past(cur_count_reg))
    else $error("count read wrong");
  page_read_a: assert property (io_hit && io_rd && ofs == DDA_OFS_PAGE |=>
    io_rdata == {8'h00, $past(page_reg)})
    else $error("page read wrong");
  // Reserved places and misses read zero and ignore writes
  rsvd_read_a: assert property (io_rd && rsvd_hit |=> io_rdata == 16'h0000)
    else $error("reserved read not zero");
  rsvd_write_a: assert property (io_wr && rsvd_hit |=>
    $stable(base_addr_reg) && $stable(page_reg) && $stable(base_count_reg))
    else $error("reserved write changed a register");
  miss_zero_a: assert property (io_rd && !io_hit |=> io_rdata == 16'h0000)
    else $error("miss read not zero");
  // Main scenarios
  cov_byte_c: cover property (!xfer_16 && xfer_done ##1 xfer_done);
  cov_word_c: cover property (xfer_16 && xfer_done ##1 xfer_done);
  cov_load_c: cover property (wr_count ##[1:8] xfer_done);
  cov_tc_c: cover property (terminal_count);
  cov_dec_c: cover property (addr_dec && xfer_done);
endmodule
`default_nettype wire

// ===== test/dda_master_model.sv
// Model of the bus master that forwards I/O accesses into the window
`timescale 1ns/1ps
`default_nettype none
module dda_master_model (
  input wire logic clk,
  input wire logic [31:0] io_base,
  output var logic [31:0] io_addr,
  output var logic io_wr,
  output var logic io_rd,
  output var logic [15:0] io_wdata,
  output var logic [1:0] io_be
);
  // Idle bus before the first access
  initial begin
    io_addr = 32'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 16'h0;
    io_be = 2'h0;
  end
  // One access held across one rising edge; released data shows its inverse
  task automatic acc(input logic wr, input logic [7:0] ofs, input logic [15:0] d,
    input logic [1:0] be);
    @(negedge clk);
    io_addr = io_base + {24'h0, ofs};
    io_wr = wr;
    io_rd = !wr;
    io_wdata = d;
    io_be = be;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = ~d;
    io_be = 2'h0;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_distributed_dma_address_count.sv
// Self-checking bench for the distributed DMA address/count block
`timescale 1ns/1ps
`default_nettype none
module tb_distributed_dma_address_count;
  import dda_pkg::*;
  logic clk, rst_n, xfer_16, xfer_done, addr_dec, io_hit, terminal_count;
  logic io_wr, io_rd;
  logic rd_q = 1'b0;
  logic [31:0] io_addr, ad_addr;
  logic [31:0] io_base = 32'h0000_1C40;
  logic [15:0] io_wdata, io_rdata, a, d, n;
  logic [15:0] exp_q[$];
  logic [7:0] p;
  logic [1:0] io_be;
  int fails = 0;
  int comparisons = 0;
  int seed = 12;
  // Clock at 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  dda_master_model PM (.clk(clk), .io_base(io_base), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_be(io_be));
  dda_core DUT (.clk(clk), .rst_n(rst_n), .io_base(io_base), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_be(io_be), .io_hit(io_hit),
    .io_rdata(io_rdata), .xfer_16(xfer_16), .xfer_done(xfer_done), .addr_dec(addr_dec),
    .ad_addr(ad_addr), .terminal_count(terminal_count));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Read results land one cycle after a taken read; oldest note is compared
  always @(posedge clk) rd_q <= io_rd & io_hit;
  always @(negedge clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else check("read data", {16'h0, io_rdata}, {16'h0, exp_q.pop_front()});
    end
  end
  task automatic rd(input logic [7:0] ofs, input logic [15:0] e);
    exp_q.push_back(e);
    PM.acc(1'b0, ofs, 16'h0, 2'h3);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [15:0] v);
    PM.acc(1'b1, ofs, v, 2'h3);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    xfer_16 = 1'b0;
    xfer_done = 1'b0;
    addr_dec = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h04, 16'h0000);
    // Both widths: program, read back, address phase, then three transfers
    for (int m = 0; m < 2; m++) begin
      a = 16'($random(seed));
      d = 16'($random(seed)) | 16'h0100;
      p = 8'($random(seed));
      xfer_16 = m[0];
      wr(8'h00, a);
      wr(8'h02, {8'h00, p});
      wr(8'h04, d);
      rd(8'h00, a);
      rd(8'h02, {8'h00, p});
      rd(8'h04, d);
      repeat (2) @(negedge clk);
      check("address phase", ad_addr, m ? {8'h00, p[7:1], a, 1'b0} : {8'h00, p, a});
      addr_dec = m[0];
      repeat (3) begin
        @(negedge clk);
        xfer_done = 1'b1;
        @(negedge clk);
        xfer_done = 1'b0;
        check("no terminal count", terminal_count, 32'h0);
      end
      n = m ? a - 16'h0003 : a + 16'h0003;
      check("moved address", ad_addr, m ? {8'h00, p[7:1], n, 1'b0} : {8'h00, p, n});
      rd(8'h04, m ? d - 16'h0006 : d - 16'h0003);
      rd(8'h00, n);
    end
    // Reserved places keep the page register and read zero
    wr(8'h06, 16'hFFFF);
    rd(8'h06, 16'h0000);
    rd(8'h02, {8'h00, p});
    rd(8'h0E, 16'h0000);
    // Byte enables choose the lanes a write touches
    PM.acc(1'b1, 8'h02, 16'hFF5A, 2'h2);
    rd(8'h02, {8'h00, p});
    PM.acc(1'b1, 8'h00, 16'hAB00, 2'h2);
    rd(8'h00, {8'hAB, a[7:0]});
    // Count taken below zero in each width gives one terminal count pulse
    for (int w = 0; w < 2; w++) begin
      xfer_16 = w[0];
      wr(8'h04, 16'h0000);
      @(negedge clk);
      xfer_done = 1'b1;
      @(negedge clk);
      xfer_done = 1'b0;
      check("terminal count", terminal_count, 32'h1);
      @(negedge clk);
      check("terminal count end", terminal_count, 32'h0);
      rd(8'h04, w ? 16'hFFFE : 16'hFFFF);
    end
    // Reset in mid-run clears registers and outputs
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check("reset address phase", ad_addr, 32'h0);
    check("reset terminal count", terminal_count, 32'h0);
    rd(8'h00, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h04, 16'h0000);
    // Access outside the window is ignored and reads zero
    PM.acc(1'b0, 8'h10, 16'h0, 2'h3);
    check("miss hit", io_hit, 32'h0);
    check("miss read data", {16'h0, io_rdata}, 32'h0);
    repeat (4) @(negedge clk);
    check("queue drained", 32'(exp_q.size()), 32'h0);
    tally_and_finish;
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
